// File: common/szc_pkg.sv
// Package with register addresses, field positions and timing constants for serial port zero.
`default_nettype none
package szc_pkg;
  localparam logic [7:0] CTRL_ADDR      = 8'h98;
  localparam logic [7:0] BUF_ADDR       = 8'h99;
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic [7:0] BUF_RESET      = 8'h00;
  localparam int         F_MODE_HI      = 7;
  localparam int         F_MODE_MID     = 6;
  localparam int         F_MODE_LO      = 5;
  localparam int         F_RX_EN        = 4;
  localparam int         F_TX_NINTH     = 3;
  localparam int         F_RX_NINTH     = 2;
  localparam int         F_TX_DONE      = 1;
  localparam int         F_RX_DONE      = 0;
  localparam int         SYNC_SLOW_CLKS = 12;
  localparam int         SYNC_FAST_CLKS = 4;
  localparam int         M2_SLOW_CLKS   = 64;
  localparam int         M2_FAST_CLKS   = 32;
  localparam int         OVERSAMPLE     = 16;
  localparam int         DATA_BITS      = 8;
  localparam int         FIFO_DEPTH     = 32;
  typedef enum logic [1:0] {
    SZC_MODE0,
    SZC_MODE1,
    SZC_MODE2,
    SZC_MODE3
  } szc_mode_e;
endpackage
`default_nettype wire

// File: common/szc_stream_if.sv
// Interface carrying a valid/ready byte stream between the port and its FIFO.
`default_nettype none
interface szc_stream_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// File: hw/szc_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
`default_nettype none
module szc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic clk_en,
  szc_stream_if.snk in_s,
  szc_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_s.ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_s.valid = (cnt_q != '0);
  assign out_s.data  = mem_q[rd_q];
  assign push        = clk_en && in_s.valid && in_s.ready;
  assign pop         = clk_en && out_s.valid && out_s.ready;

  always_ff @(posedge ref_clk)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_s.data;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// File: hw/szc_serial_port.sv
// Serial port zero: control register, transmit FIFO, transmitter and receiver.
// Operation
// - Mode field 000/001 is synchronous 8-bit, 12 or 4 clocks per bit.
// - Asynchronous modes frame data with one start and one stop bit.
// - Field 010 is mode 1 on selected timer, 011 on timer 1 only.
// - Mode 1 with low bit set raises receive flag only on valid stop.
// - Field 10x is mode 2, 11 bits, 64 or 32 clocks per bit.
// - Field 11x is mode 3, 11 bits, timer baud rate.
// - Modes 2/3 with low bit set ignore frames whose ninth bit is 0.
// - Timer 2 control selection picks timer 1 or 2 baud for modes 1/3.
// - Receive enable gates reception; in mode 0 it starts one reception.
// - Modes 2/3 transmit the ninth transmit bit as ninth data bit.
// - Ninth receive bit captures bit 9, or stop bit in mode 1.
// - Transmit flag set after last data bit; software clears it.
// - Receive flag set after last bit sample; software clears it.
// - Buffer address writes transmit data and reads receive data.
`default_nettype none
module szc_serial_port #(
  parameter int FIFO_WORDS = szc_pkg::FIFO_DEPTH
) (
  input  wire logic       ref_clk,
  input  wire logic       srst,
  input  wire logic       clk_en,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  input  wire logic       baud_double_select,
  input  wire logic       timer_two_baud_sel,
  input  wire logic       timer1_baud_tick,
  input  wire logic       timer2_baud_tick,
  output logic            txd_out,
  input  wire logic       rxd_in,
  output logic            rxd_out,
  output logic            rxd_oe,
  output logic            tx_fifo_ready
);
  logic [7:0] ctrl_q;
  logic [7:0] rx_buf_q;
  logic       rxd_m_q;
  logic       rxd_s_q;
  logic       rxd_prev_q;
  logic       t1_q;
  logic       t2_q;
  szc_pkg::szc_mode_e mode;
  logic       low_bit;
  logic       tick16;
  logic [3:0] tx_pre_q;
  logic       tx_tick;
  logic [6:0] div_q;
  logic [6:0] div_len;
  logic       tx_busy_q;
  logic [3:0] tx_cnt_q;
  logic [10:0] tx_sh_q;
  logic       tx_done_set;
  logic       rx_busy_q;
  logic [3:0] rx_cnt_q;
  logic [3:0] rx_pre_q;
  logic [9:0] rx_sh_q;
  logic       rx_done_set;
  logic       rx_ninth_set;
  logic       rx_ninth_val;
  logic [7:0] rx_word;
  logic       m0_phase_q;
  logic [3:0] tx_len;
  logic [3:0] rx_len;
  logic       ctrl_wr;
  logic       tx_load;
  logic       rx_m0_start;
  logic [3:0] tx_flag_cnt;

  szc_stream_if #(.WIDTH(8)) wr_s ();
  szc_stream_if #(.WIDTH(8)) rd_s ();

  szc_fifo #(.WIDTH(8), .DEPTH(FIFO_WORDS)) u_fifo (
    .ref_clk (ref_clk),
    .srst    (srst),
    .clk_en  (clk_en),
    .in_s    (wr_s),
    .out_s   (rd_s)
  );

  assign wr_s.data  = sfr_wdata;
  assign wr_s.valid = sfr_wr && (sfr_addr == szc_pkg::BUF_ADDR);
  assign ctrl_wr    = sfr_wr && (sfr_addr == szc_pkg::CTRL_ADDR);
  assign low_bit    = ctrl_q[szc_pkg::F_MODE_LO];

  // Mode decode from the high and middle field bits.
  always_comb
  begin
    unique case ({ctrl_q[szc_pkg::F_MODE_HI], ctrl_q[szc_pkg::F_MODE_MID]})
      2'b00: mode = szc_pkg::SZC_MODE0;
      2'b01: mode = szc_pkg::SZC_MODE1;
      2'b10: mode = szc_pkg::SZC_MODE2;
      2'b11: mode = szc_pkg::SZC_MODE3;
    endcase
  end

  // Baud source for modes 1 and 3; field 011 forces timer 1.
  always_comb
  begin
    if (mode == szc_pkg::SZC_MODE1 && low_bit)
    begin
      tick16 = t1_q;
    end
    else
    begin
      tick16 = timer_two_baud_sel ? t2_q : t1_q;
    end
  end

  // Mode 0 and mode 2 use a fixed divider, in mode 2 yielding sixteenths of a bit.
  always_comb
  begin
    if (mode == szc_pkg::SZC_MODE0)
    begin
      div_len = low_bit ? 7'(szc_pkg::SYNC_FAST_CLKS / 2 - 1)
                        : 7'(szc_pkg::SYNC_SLOW_CLKS / 2 - 1);
    end
    else
    begin
      div_len = baud_double_select ? 7'(szc_pkg::M2_FAST_CLKS / szc_pkg::OVERSAMPLE - 1)
                                   : 7'(szc_pkg::M2_SLOW_CLKS / szc_pkg::OVERSAMPLE - 1);
    end
  end

  logic div_tick;
  assign div_tick = (div_q == div_len);
  logic os_tick;
  assign os_tick = (mode == szc_pkg::SZC_MODE2) ? div_tick : tick16;
  assign tx_tick = os_tick && (tx_pre_q == 4'(szc_pkg::OVERSAMPLE - 1));

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      div_q    <= '0;
      tx_pre_q <= '0;
    end
    else if (clk_en)
    begin
      // A new transmission or mode 0 reception restarts the bit timing so that its first bit is full length.
      if (tx_load || rx_m0_start)
      begin
        div_q    <= '0;
        tx_pre_q <= '0;
      end
      else
      begin
        div_q <= div_tick ? '0 : div_q + 1'b1;
        if (os_tick)
        begin
          tx_pre_q <= tx_pre_q + 1'b1;
        end
      end
    end
  end

  // Pin inputs pass two flip-flops.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      rxd_m_q    <= 1'b1;
      rxd_s_q    <= 1'b1;
      rxd_prev_q <= 1'b1;
      t1_q       <= 1'b0;
      t2_q       <= 1'b0;
    end
    else if (clk_en)
    begin
      rxd_m_q    <= rxd_in;
      rxd_s_q    <= rxd_m_q;
      rxd_prev_q <= rxd_s_q;
      t1_q       <= timer1_baud_tick;
      t2_q       <= timer2_baud_tick;
    end
  end

  assign tx_len = (mode == szc_pkg::SZC_MODE0) ? 4'(szc_pkg::DATA_BITS)
                : (mode == szc_pkg::SZC_MODE1) ? 4'(szc_pkg::DATA_BITS + 2)
                : 4'(szc_pkg::DATA_BITS + 3);
  assign rx_len = (mode == szc_pkg::SZC_MODE0) ? 4'(szc_pkg::DATA_BITS)
                : 4'(szc_pkg::DATA_BITS + 2);
  assign tx_flag_cnt = (mode == szc_pkg::SZC_MODE0) ? tx_len - 4'd1 : tx_len - 4'd2;

  // Transmitter: pulls a byte from the FIFO and shifts it out LSB first.
  assign rd_s.ready  = clk_en && !tx_busy_q && !rx_busy_q;
  assign tx_load     = rd_s.valid && rd_s.ready;
  assign tx_done_set = clk_en && tx_busy_q && tx_cnt_q == tx_flag_cnt &&
                       (mode == szc_pkg::SZC_MODE0 ? (div_tick && m0_phase_q) : tx_tick);

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      tx_busy_q  <= 1'b0;
      tx_cnt_q   <= '0;
      tx_sh_q    <= '1;
      m0_phase_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (rd_s.valid && rd_s.ready)
      begin
        tx_busy_q  <= 1'b1;
        tx_cnt_q   <= '0;
        m0_phase_q <= 1'b0;
        if (mode == szc_pkg::SZC_MODE0)
        begin
          tx_sh_q <= {3'b111, rd_s.data};
        end
        else
        begin
          tx_sh_q <= {1'b1, ctrl_q[szc_pkg::F_TX_NINTH] | (mode == szc_pkg::SZC_MODE1),
                      rd_s.data, 1'b0};
        end
      end
      else if (tx_busy_q)
      begin
        if (mode == szc_pkg::SZC_MODE0 ? div_tick : tx_tick)
        begin
          m0_phase_q <= ~m0_phase_q;
          if (mode != szc_pkg::SZC_MODE0 || m0_phase_q)
          begin
            tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
            tx_cnt_q <= tx_cnt_q + 1'b1;
            if (tx_cnt_q == tx_len - 1'b1)
            begin
              tx_busy_q <= 1'b0;
            end
          end
        end
      end
      else if (rx_m0_start)
      begin
        m0_phase_q <= 1'b0;
      end
      else if (rx_busy_q && mode == szc_pkg::SZC_MODE0 && div_tick)
      begin
        m0_phase_q <= ~m0_phase_q;
      end
    end
  end

  // Receiver: start-bit detect, mid-bit sample at the oversample centre.
  assign rx_word      = rx_sh_q[9:2];
  assign rx_ninth_val = rxd_s_q;
  assign rx_ninth_set = rx_done_set && mode != szc_pkg::SZC_MODE0;
  logic rx_last;
  logic rx_sample;
  assign rx_sample = (mode == szc_pkg::SZC_MODE0) ? (div_tick && m0_phase_q)
                   : (os_tick && rx_pre_q == 4'(szc_pkg::OVERSAMPLE / 2 - 1));
  assign rx_last   = rx_busy_q && rx_sample && rx_cnt_q == rx_len - 1'b1;
  assign rx_m0_start = ctrl_wr && !tx_busy_q && !rx_busy_q && !sfr_wdata[szc_pkg::F_MODE_HI]
                       && !sfr_wdata[szc_pkg::F_MODE_MID] && sfr_wdata[szc_pkg::F_RX_EN]
                       && !sfr_wdata[szc_pkg::F_RX_DONE];

  always_comb
  begin
    rx_done_set = 1'b0;
    if (rx_last)
    begin
      unique case (mode)
        szc_pkg::SZC_MODE0: rx_done_set = 1'b1;
        szc_pkg::SZC_MODE1: rx_done_set = !low_bit || rxd_s_q;
        szc_pkg::SZC_MODE2,
        szc_pkg::SZC_MODE3: rx_done_set = !low_bit || rxd_s_q;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      rx_busy_q <= 1'b0;
      rx_cnt_q  <= '0;
      rx_pre_q  <= '0;
      rx_sh_q   <= '0;
      rx_buf_q  <= szc_pkg::BUF_RESET;
    end
    else if (clk_en)
    begin
      if (!rx_busy_q && (rx_m0_start || (mode != szc_pkg::SZC_MODE0 &&
          ctrl_q[szc_pkg::F_RX_EN] && rxd_prev_q && !rxd_s_q)))
      begin
        rx_busy_q <= 1'b1;
        rx_cnt_q  <= '0;
        rx_pre_q  <= '0;
      end
      else if (!ctrl_q[szc_pkg::F_RX_EN])
      begin
        rx_busy_q <= 1'b0;
      end
      else if (rx_busy_q)
      begin
        if (os_tick)
        begin
          rx_pre_q <= rx_pre_q + 1'b1;
        end
        if (rx_sample)
        begin
          rx_sh_q  <= {rxd_s_q, rx_sh_q[9:1]};
          rx_cnt_q <= rx_cnt_q + 1'b1;
          if (mode != szc_pkg::SZC_MODE0 && rx_cnt_q == '0 && rxd_s_q)
          begin
            rx_busy_q <= 1'b0;
          end
          if (rx_last)
          begin
            rx_busy_q <= 1'b0;
            if (rx_done_set)
            begin
              rx_buf_q <= (mode == szc_pkg::SZC_MODE0) ? {rxd_s_q, rx_sh_q[9:3]} : rx_word;
            end
          end
        end
      end
    end
  end

  // Control register; hardware flag sets win over a software write.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      ctrl_q <= szc_pkg::CTRL_RESET;
    end
    else if (clk_en)
    begin
      if (ctrl_wr)
      begin
        ctrl_q <= sfr_wdata;
      end
      if (tx_done_set)
      begin
        ctrl_q[szc_pkg::F_TX_DONE] <= 1'b1;
      end
      if (rx_done_set)
      begin
        ctrl_q[szc_pkg::F_RX_DONE] <= 1'b1;
      end
      if (rx_ninth_set)
      begin
        ctrl_q[szc_pkg::F_RX_NINTH] <= rx_ninth_val;
      end
      if (mode == szc_pkg::SZC_MODE0 && rx_last)
      begin
        ctrl_q[szc_pkg::F_RX_EN] <= 1'b0;
      end
    end
  end

  // Registered outputs: read data and pin drive.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      sfr_rdata     <= '0;
      txd_out       <= 1'b1;
      rxd_out       <= 1'b1;
      rxd_oe        <= 1'b0;
      tx_fifo_ready <= 1'b1;
    end
    else if (clk_en)
    begin
      if (sfr_rd)
      begin
        sfr_rdata <= (sfr_addr == szc_pkg::CTRL_ADDR) ? ctrl_q
                   : (sfr_addr == szc_pkg::BUF_ADDR) ? rx_buf_q : '0;
      end
      tx_fifo_ready <= wr_s.ready;
      if (mode == szc_pkg::SZC_MODE0)
      begin
        txd_out <= !((tx_busy_q || rx_busy_q) && !m0_phase_q);
        rxd_out <= tx_sh_q[0];
        rxd_oe  <= tx_busy_q;
      end
      else
      begin
        txd_out <= tx_busy_q ? tx_sh_q[0] : 1'b1;
        rxd_out <= 1'b1;
        rxd_oe  <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: verif/szc_serial_port_monitor.sv
// Checker for register answers and pin timing of serial port zero.
`default_nettype none
module szc_serial_port_monitor (
  input wire logic       ref_clk,
  input wire logic       srst,
  input wire logic       clk_en,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       baud_double_select,
  input wire logic       txd_out,
  input wire logic       rxd_oe,
  input wire logic       tx_fifo_ready
);
  logic [7:0] ctrl_q;
  logic [7:0] run_q;
  logic [7:0] gap_q;
  logic       txd_q;
  logic       wr_ctrl;
  assign wr_ctrl = sfr_wr && clk_en && sfr_addr == szc_pkg::CTRL_ADDR;
  // Run lengths saturate and are loaded full on control writes so mode changes never look short.
  always_ff @(posedge ref_clk)
  begin
    txd_q <= txd_out;
    ctrl_q <= srst ? 8'h00 : (wr_ctrl ? sfr_wdata : ctrl_q);
    if (srst || wr_ctrl) run_q <= 8'hff;
    else if (txd_out != txd_q) run_q <= 8'h00;
    else if (run_q != 8'hff) run_q <= run_q + 8'h01;
    if (srst || wr_ctrl) gap_q <= 8'hff;
    else if (txd_q && !txd_out) gap_q <= 8'h00;
    else if (gap_q != 8'hff) gap_q <= gap_q + 8'h01;
  end
  a_reset_pin_idle: assert property (@(posedge ref_clk)
    srst |=> txd_out && !rxd_oe && tx_fifo_ready) else $error("pins not idle after reset");
  a_unmapped_zero: assert property (@(posedge ref_clk) disable iff (srst)
    sfr_rd && clk_en && sfr_addr != szc_pkg::CTRL_ADDR && sfr_addr != szc_pkg::BUF_ADDR
    |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
  a_rdata_holds: assert property (@(posedge ref_clk) disable iff (srst)
    !$past(sfr_rd) |-> $stable(sfr_rdata)) else $error("read data moved without read");
  a_ctrl_readback: assert property (@(posedge ref_clk) disable iff (srst)
    sfr_rd && clk_en && sfr_addr == szc_pkg::CTRL_ADDR
    |=> sfr_rdata[7:5] == ctrl_q[7:5] && sfr_rdata[3] == ctrl_q[3])
    else $error("control readback wrong");
  a_sync_slow_clk: assert property (@(posedge ref_clk) disable iff (srst)
    ctrl_q[7:5] == 3'b000 && txd_q && !txd_out |-> gap_q >= 8'd11)
    else $error("slow shift clock too fast");
  a_sync_fast_clk: assert property (@(posedge ref_clk) disable iff (srst)
    ctrl_q[7:5] == 3'b001 && txd_q && !txd_out |-> gap_q >= 8'd3)
    else $error("fast shift clock too fast");
  a_mode2_slow_bit: assert property (@(posedge ref_clk) disable iff (srst)
    ctrl_q[7:6] == 2'b10 && !baud_double_select && txd_out != txd_q |-> run_q >= 8'd63)
    else $error("mode 2 bit under 64 clocks");
  a_mode2_fast_bit: assert property (@(posedge ref_clk) disable iff (srst)
    ctrl_q[7:6] == 2'b10 && baud_double_select && txd_out != txd_q |-> run_q >= 8'd31)
    else $error("mode 2 bit under 32 clocks");
  a_async_no_drive: assert property (@(posedge ref_clk) disable iff (srst)
    ctrl_q[7:6] != 2'b00 |-> !rxd_oe) else $error("receive pin driven in async mode");
endmodule
bind szc_serial_port szc_serial_port_monitor i_mon (.ref_clk, .srst, .clk_en, .sfr_addr,
  .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .baud_double_select, .txd_out, .rxd_oe,
  .tx_fifo_ready);
`default_nettype wire

// File: verif/szc_peer_model.sv
// Remote asynchronous serial device: sends frames to the port and decodes its frames.
`default_nettype none
module szc_peer_model (
  input  wire logic ref_clk,
  input  wire logic txd_pin,
  output var logic  rxd_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rxd_pin = 1'b1;
  // A bad stop is held short so its tail cannot pass for a new start.
  task automatic send_frame(input logic [8:0] b, input int n, input int per, input logic stp);
    int i;
    @(negedge ref_clk) rxd_pin = 1'b0;
    repeat (per) @(negedge ref_clk);
    for (i = 0; i < n; i++)
    begin
      rxd_pin = b[i];
      repeat (per) @(negedge ref_clk);
    end
    rxd_pin = stp;
    repeat (stp ? per : per * 3 / 4) @(negedge ref_clk);
    rxd_pin = 1'b1;
  endtask
  // Mode 0 data: bit 0 is set up at once, each later bit just after the port's shift clock falls.
  task automatic send_sync(input logic [7:0] b);
    int i;
    rxd_pin = b[0];
    @(negedge txd_pin);
    for (i = 1; i < 8; i++)
    begin
      @(negedge txd_pin);
      @(negedge ref_clk) rxd_pin = b[i];
    end
    @(posedge txd_pin);
    repeat (12) @(negedge ref_clk);
    rxd_pin = 1'b1;
  endtask
  task automatic get_frame(input int n, input int per, output logic [8:0] b, output logic ok);
    int i;
    b = 9'h000;
    for (i = 0; i < 4000 && txd_pin; i++) @(negedge ref_clk);
    ok = !txd_pin;
    repeat (per / 2) @(negedge ref_clk);
    for (i = 0; i < n; i++)
    begin
      repeat (per) @(negedge ref_clk);
      b[i] = txd_pin;
    end
    repeat (per) @(negedge ref_clk);
    ok = ok && txd_pin;
  endtask
endmodule
`default_nettype wire

// File: verif/serial_port_zero_control_tb_top.sv
// Self-checking bench for serial port zero.
`default_nettype none
module serial_port_zero_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] ctrl;
    logic       sel;
    logic       dbl;
    logic [7:0] dat;
    logic [8:0] exp;
    int         n;
    int         per;
  } szc_row_s;
  localparam logic [7:0] CA = szc_pkg::CTRL_ADDR;
  localparam logic [7:0] BA = szc_pkg::BUF_ADDR;
  localparam szc_row_s ROWS [6] = '{
    '{8'h40, 1'b0, 1'b0, 8'ha5, 9'h0a5, 8, 64},
    '{8'h40, 1'b1, 1'b0, 8'h3c, 9'h03c, 8, 32},
    '{8'h60, 1'b1, 1'b0, 8'hc3, 9'h0c3, 8, 64},
    '{8'h88, 1'b0, 1'b0, 8'h5a, 9'h15a, 9, 64},
    '{8'h80, 1'b0, 1'b1, 8'h81, 9'h081, 9, 32},
    '{8'hc8, 1'b1, 1'b0, 8'h7e, 9'h17e, 9, 32}};
  logic       ref_clk, srst, clk_en, sfr_wr, sfr_rd, dbl, sel, t1, t2;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, d, tcnt;
  logic       txd_out, rxd_out, rxd_oe, tx_fifo_ready, peer_rxd, ok;
  wire  logic rxd_w;
  logic [8:0] bits;
  int         n_errors, samples_checked, cyc, t;
  assign rxd_w = rxd_oe ? rxd_out : peer_rxd;
  szc_serial_port i_dut (.ref_clk(ref_clk), .srst(srst), .clk_en(clk_en),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .baud_double_select(dbl), .timer_two_baud_sel(sel),
    .timer1_baud_tick(t1), .timer2_baud_tick(t2), .txd_out(txd_out), .rxd_in(rxd_w),
    .rxd_out(rxd_out), .rxd_oe(rxd_oe), .tx_fifo_ready(tx_fifo_ready));
  szc_peer_model i_peer (.ref_clk(ref_clk), .txd_pin(txd_out), .rxd_pin(peer_rxd));
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Timer 1 ticks every 4 clocks give 64-clock bits, timer 2 every 2 clocks give 32.
  always @(negedge ref_clk)
  begin
    tcnt <= tcnt + 8'h01;
    t1 <= tcnt[1:0] == 2'b00;
    t2 <= tcnt[0];
  end
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge ref_clk) {sfr_addr, sfr_wdata, sfr_wr} = {a, v, 1'b1};
    @(negedge ref_clk) sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge ref_clk) {sfr_addr, sfr_rd} = {a, 1'b1};
    @(negedge ref_clk) sfr_rd = 1'b0;
    @(negedge ref_clk) v = sfr_rdata;
  endtask
  task automatic rxt(input logic [7:0] c, input logic [8:0] b, input int n,
                     input logic stp, input logic [1:0] ef);
    logic [7:0] v;
    wr(CA, c);
    i_peer.send_frame(b, n, 64, stp);
    repeat (64) @(negedge ref_clk);
    rd(CA, v);
    chk(9'(v[0]), 9'(ef[0]));
    if (v[0])
    begin
      chk(9'(v[2]), 9'(ef[1]));
      rd(BA, v);
      chk(9'(v), 9'(b[7:0]));
    end
    $display("receive case done");
  endtask
  task automatic sync_tx(input logic [7:0] c, input int eg);
    int g;
    wr(CA, c);
    wr(BA, 8'h96);
    for (g = 0; g < 200 && txd_out; g++) @(negedge ref_clk);
    chk(9'(rxd_oe), 9'h001);
    g = 0;
    while (!txd_out && g < 100)
    begin
      @(negedge ref_clk);
      g++;
    end
    while (txd_out && g < 100)
    begin
      @(negedge ref_clk);
      g++;
    end
    chk(9'(g), 9'(eg));
    repeat (200) @(negedge ref_clk);
    rd(CA, d);
    chk(9'(d[1]), 9'h001);
    $display("sync case done");
  endtask
  initial
  begin
    {srst, clk_en, sfr_wr, sfr_rd, dbl, sel, t1, t2} = 8'b1100_0000;
    {sfr_addr, sfr_wdata, tcnt} = 24'h00_0000;
    repeat (2) @(negedge ref_clk);
    srst = 1'b0;
    for (int k = 0; k < 6; k++)
    begin
      {dbl, sel} = {ROWS[k].dbl, ROWS[k].sel};
      wr(CA, ROWS[k].ctrl);
      wr(BA, ROWS[k].dat);
      i_peer.get_frame(ROWS[k].n, ROWS[k].per, bits, ok);
      chk(bits, ROWS[k].exp);
      chk(9'(ok), 9'h001);
      repeat (100) @(negedge ref_clk);
      rd(CA, d);
      chk(9'(d[1]), 9'h001);
      $display("row %0d done", k);
    end
    wr(CA, 8'h00);
    rd(CA, d);
    chk(9'(d), 9'h000);
    rd(8'h9a, d);
    chk(9'(d), 9'h000);
    {dbl, sel} = 2'b00;
    rxt(8'h50, 9'h0a5, 8, 1'b1, 2'b11);
    rxt(8'h70, 9'h05a, 8, 1'b0, 2'b00);
    rxt(8'hb0, 9'h05a, 9, 1'b1, 2'b00);
    rxt(8'hb0, 9'h1c3, 9, 1'b1, 2'b11);
    rxt(8'h40, 9'h0c3, 8, 1'b1, 2'b00);
    sync_tx(8'h00, 12);
    sync_tx(8'h20, 4);
    fork
      wr(CA, 8'h10);
      i_peer.send_sync(8'hc6);
    join
    repeat (20) @(negedge ref_clk);
    rd(CA, d);
    chk(9'({d[4], d[0]}), 9'h001);
    rd(BA, d);
    chk(9'(d), 9'h0c6);
    $display("sync receive case done");
    dbl = 1'b1;
    wr(CA, 8'h80);
    repeat (36) wr(BA, 8'h55);
    chk(9'(tx_fifo_ready), 9'h000);
    for (t = 0; t < 2000 && !tx_fifo_ready; t++) @(negedge ref_clk);
    chk(9'(tx_fifo_ready), 9'h001);
    $display("fifo case done");
    give_verdict();
  end
endmodule
`default_nettype wire
